// [core/scr_config_regs.v]
// Serializer configuration register bank with control-channel timeout timers.
`timescale 1ns/1ps
`include "scr_defs.vh"
module scr_config_regs (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Remote configuration strap pin
  input wire remoteConfigInput,
  // Register access from the control-channel packet decoder
  input wire regWrite,
  input wire regRead,
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  output reg regRvalid,
  // Control-channel session events
  input wire sessionOpen,
  input wire sessionClose,
  input wire channelUse,
  input wire pixelTick,
  output reg startTimeout,
  output reg endTimeout,
  // Configuration outputs
  output reg [1:0] pixelClockRange,
  output reg [1:0] serialRateRange,
  output reg videoParityOn,
  output reg [2:0] parallelWordWidth,
  output reg [2:0] spreadSelect,
  output reg spreadOn,
  output reg vsyncEdgeSelect,
  output reg pixelClockEdgeSelect,
  output reg powerDown,
  output reg serializeOn,
  output reg jitterPllBypass,
  output reg testPatternOn,
  output reg [6:0] ownLinkAddress,
  output reg [6:0] closingFrameValue,
  output reg [6:0] partnerLinkAddress,
  output reg peripheralIfSelect,
  output reg peripheralIfOn,
  output reg fastBand,
  output reg [6:0] bypassReturnBits,
  output reg [1:0] baseRateRange
);

  // ****************************************************************
  // Strap synchroniser and register storage
  // ****************************************************************
  reg [2:0] remSync_r;
  reg strapDone_r;
  reg [7:0] rate_r, spread_r, sto_r, eto_r, ctrl_r, own_r, ef_r, part_r, link_r;
  reg inSession_r;

  // The strap synchroniser is kept out of reset on purpose.
  // It goes on sampling the pin while reset is held, so its second and third stages already
  // agree on the strap level at the first edge after release, when the strap is taken in.
  // Clearing it in reset would make the strap read as low on that edge, whatever the pin says.
  // The pin must therefore be steady for at least two edges before reset is released.
  always @(posedge mclk) begin
    remSync_r <= {remSync_r[1:0], remoteConfigInput};
  end

  // Register writes land on the edge that samples the write strobe.
  // Reserved bits are forced to their fixed levels here, so a read always returns them
  // as the hardware uses them, whatever the controller wrote.
  // Writes to indices above the last register are dropped without any effect.
  // The spread code is stored as written; keeping it within the limit of the pixel-clock
  // range is left to whoever programs the bank.

  always @(posedge mclk) begin
    if (!reset_n) begin
      rate_r <= `SCR_RST_RATE;
      spread_r <= `SCR_RST_SPREAD;
      sto_r <= `SCR_RST_TO;
      eto_r <= `SCR_RST_TO;
      ctrl_r <= `SCR_RST_CTRL;
      own_r <= `SCR_RST_OWN;
      ef_r <= `SCR_RST_EF;
      part_r <= `SCR_RST_PART;
      link_r <= `SCR_RST_LINK;
      strapDone_r <= 1'b0;
    end else begin
      // The strap is caught once, when the synchroniser has settled after release.
      if (!strapDone_r) begin
        strapDone_r <= 1'b1;
        if (remSync_r[2] && remSync_r[1]) begin
          ctrl_r <= `SCR_RST_CTRL_REM;
        end
      end
      if (regWrite) begin
        case (regAddr)
          `SCR_A_RATE: rate_r <= regWdata;
          `SCR_A_SPREAD: spread_r <= regWdata;
          `SCR_A_STO: sto_r <= regWdata;
          `SCR_A_ETO: eto_r <= regWdata;
          `SCR_A_CTRL: ctrl_r <= regWdata & `SCR_MASK_CTRL;
          `SCR_A_OWN: own_r <= regWdata & `SCR_MASK_ADDR;
          `SCR_A_EF: ef_r <= regWdata | 8'h01;
          `SCR_A_PART: part_r <= regWdata & `SCR_MASK_ADDR;
          `SCR_A_LINK: link_r <= regWdata;
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Read data is registered and stands until the next read; valid follows the read strobe one cycle later, for as long as it is held.
  // Unused indices read as zero.
  reg [7:0] rdMux;
  always @* begin
    case (regAddr)
      `SCR_A_RATE: rdMux = rate_r;
      `SCR_A_SPREAD: rdMux = spread_r;
      `SCR_A_STO: rdMux = sto_r;
      `SCR_A_ETO: rdMux = eto_r;
      `SCR_A_CTRL: rdMux = ctrl_r;
      `SCR_A_OWN: rdMux = own_r;
      `SCR_A_EF: rdMux = ef_r;
      `SCR_A_PART: rdMux = part_r;
      `SCR_A_LINK: rdMux = link_r;
      default: rdMux = 8'h00;
    endcase
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      regRdata <= 8'h00;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        regRdata <= rdMux;
      end
    end
  end

  // ****************************************************************
  // Timeout timers, one per start and end
  // ****************************************************************
  // Both timers run on prescaled pixel-clock ticks. The prescaler counts pixelTick pulses
  // up to the divisor, and each wrap advances the timer counter by one.
  // A timer fires after (count field + 1) wraps, that is (count + 1) * divisor ticks.
  // The start timer runs from session open until the first use of the channel.
  // The end timer runs only once the channel has been used, and any further use restarts it.
  // Either timeout closes the session, so at most one pulse is produced per session.
  // The divisor is taken from the live register value, so a rewrite in mid-session takes
  // effect on the next prescaler compare; the prescaler itself is not cleared by it.
  function [15:0] preDiv;
    input [3:0] code;
    begin
      if (code <= 4'h4) begin
        preDiv = 16'h0010;
      end else begin
        preDiv = 16'h0001 << code;
      end
    end
  endfunction

  reg used_r;
  reg [14:0] stoPre_r, etoPre_r;
  reg [4:0] start_timeout_count_r, end_timeout_count_r;
  wire [15:0] start_timeout_prescale = preDiv(sto_r[7:4]);
  wire [15:0] end_timeout_prescale = preDiv(eto_r[7:4]);
  wire stoTick = pixelTick && ({1'b0, stoPre_r} == start_timeout_prescale - 16'h0001);
  wire etoTick = pixelTick && ({1'b0, etoPre_r} == end_timeout_prescale - 16'h0001);

  always @(posedge mclk) begin
    if (!reset_n) begin
      inSession_r <= 1'b0;
      used_r <= 1'b0;
      stoPre_r <= 15'h0000;
      etoPre_r <= 15'h0000;
      start_timeout_count_r <= 5'h00;
      end_timeout_count_r <= 5'h00;
      startTimeout <= 1'b0;
      endTimeout <= 1'b0;
    end else begin
      startTimeout <= 1'b0;
      endTimeout <= 1'b0;
      if (sessionOpen) begin
        inSession_r <= 1'b1;
        used_r <= 1'b0;
        stoPre_r <= 15'h0000;
        start_timeout_count_r <= 5'h00;
        etoPre_r <= 15'h0000;
        end_timeout_count_r <= 5'h00;
      end else if (sessionClose) begin
        inSession_r <= 1'b0;
      end else if (inSession_r) begin
        if (channelUse) begin
          used_r <= 1'b1;
          etoPre_r <= 15'h0000;
          end_timeout_count_r <= 5'h00;
        end else if (used_r) begin
          if (pixelTick) begin
            etoPre_r <= etoTick ? 15'h0000 : etoPre_r + 15'h0001;
          end
          if (etoTick) begin
            if (end_timeout_count_r == {1'b0, eto_r[3:0]}) begin
              endTimeout <= 1'b1;
              inSession_r <= 1'b0;
            end else begin
              end_timeout_count_r <= end_timeout_count_r + 5'h01;
            end
          end
        end else begin
          if (pixelTick) begin
            stoPre_r <= stoTick ? 15'h0000 : stoPre_r + 15'h0001;
          end
          if (stoTick) begin
            if (start_timeout_count_r == {1'b0, sto_r[3:0]}) begin
              startTimeout <= 1'b1;
              inSession_r <= 1'b0;
            end else begin
              start_timeout_count_r <= start_timeout_count_r + 5'h01;
            end
          end
        end
      end
    end
  end

  // ****************************************************************
  // Configuration outputs
  // ****************************************************************
  // Every configuration output is a flip-flop, one cycle behind its register except baseRateRange, so the
  // consumers never see a combinational path from the register write port.
  // The base-mode bit rate is captured only at session open, so a write to it in a running
  // session is held back until the next one, while the fast-band bit follows at once.
  // The return timer code is scaled to bit times here; code zero means never return.
  wire [31:0] returnBitsFull = link_r[4:2] * `SCR_RETURN_STEP;

  always @(posedge mclk) begin
    if (!reset_n) begin
      pixelClockRange <= 2'h2;
      serialRateRange <= 2'h3;
      videoParityOn <= 1'b0;
      parallelWordWidth <= 3'h5;
      spreadSelect <= 3'h0;
      spreadOn <= 1'b0;
      vsyncEdgeSelect <= 1'b0;
      pixelClockEdgeSelect <= 1'b1;
      powerDown <= 1'b0;
      serializeOn <= 1'b1;
      jitterPllBypass <= 1'b0;
      testPatternOn <= 1'b0;
      ownLinkAddress <= 7'h7d;
      closingFrameValue <= 7'h7f;
      partnerLinkAddress <= 7'h7c;
      peripheralIfSelect <= 1'b0;
      peripheralIfOn <= 1'b0;
      fastBand <= 1'b0;
      bypassReturnBits <= 7'h00;
      baseRateRange <= 2'h0;
    end else begin
      pixelClockRange <= rate_r[7:6];
      serialRateRange <= rate_r[5:4];
      videoParityOn <= rate_r[3];
      parallelWordWidth <= rate_r[2:0];
      spreadSelect <= spread_r[7:5];
      spreadOn <= (spread_r[6:5] != 2'h0);
      vsyncEdgeSelect <= ctrl_r[7];
      pixelClockEdgeSelect <= ctrl_r[5];
      powerDown <= ctrl_r[4];
      serializeOn <= ctrl_r[3];
      jitterPllBypass <= ctrl_r[2];
      testPatternOn <= ctrl_r[0];
      ownLinkAddress <= own_r[7:1];
      closingFrameValue <= ef_r[7:1];
      partnerLinkAddress <= part_r[7:1];
      peripheralIfSelect <= link_r[7];
      peripheralIfOn <= link_r[6];
      fastBand <= link_r[`SCR_BIT_FAST];
      bypassReturnBits <= returnBitsFull[6:0];
      if (sessionOpen) begin
        baseRateRange <= link_r[1:0];
      end
    end
  end

endmodule

// [core/scr_defs.vh]
// Constants for the serializer configuration register bank.
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH
`define SCR_A_RATE 4'h0
`define SCR_A_SPREAD 4'h1
`define SCR_A_STO 4'h2
`define SCR_A_ETO 4'h3
`define SCR_A_CTRL 4'h4
`define SCR_A_OWN 4'h5
`define SCR_A_EF 4'h6
`define SCR_A_PART 4'h7
`define SCR_A_LINK 4'h8
`define SCR_RST_RATE 8'hb5
`define SCR_RST_SPREAD 8'h1f
`define SCR_RST_TO 8'ha0
`define SCR_RST_CTRL 8'h28
`define SCR_RST_CTRL_REM 8'h30
`define SCR_RST_OWN 8'hfa
`define SCR_RST_EF 8'hff
`define SCR_RST_PART 8'hf8
`define SCR_RST_LINK 8'h00
`define SCR_MASK_CTRL 8'hbd
`define SCR_MASK_ADDR 8'hfe
`define SCR_BIT_FAST 5
`define SCR_RETURN_STEP 16
`endif

// [tb/scr_config_regs_properties.sv]
// Port-level checker for the configuration register bank.
`timescale 1ns/1ps
module scr_config_regs_properties (
  // Clock, reset and requests
  input logic mclk,
  input logic reset_n,
  input logic regWrite,
  input logic [3:0] regAddr,
  input logic [7:0] regWdata,
  input logic sessionOpen,
  // Observed outputs
  input logic startTimeout,
  input logic endTimeout,
  input logic [1:0] pixelClockRange,
  input logic [1:0] serialRateRange,
  input logic [2:0] spreadSelect,
  input logic spreadOn,
  input logic powerDown,
  input logic [6:0] ownLinkAddress,
  input logic fastBand,
  input logic [6:0] bypassReturnBits,
  input logic [1:0] baseRateRange
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_rate_fields: assert property (regWrite && regAddr == 4'h0 |-> ##2
    pixelClockRange == $past(regWdata[7:6], 2) && serialRateRange == $past(regWdata[5:4], 2))
    else $error("rate");
  a_spread_code: assert property (regWrite && regAddr == 4'h1 |-> ##2
    spreadSelect == $past(regWdata[7:5], 2) && spreadOn == ($past(regWdata[6:5], 2) != 2'b00))
    else $error("spread");
  a_power_bit: assert property (regWrite && regAddr == 4'h4 |-> ##2
    powerDown == $past(regWdata[4], 2)) else $error("power");
  a_own_addr: assert property (regWrite && regAddr == 4'h5 |-> ##2
    ownLinkAddress == $past(regWdata[7:1], 2)) else $error("address");
  a_fast_now: assert property (regWrite && regAddr == 4'h8 |-> ##2
    fastBand == $past(regWdata[5], 2) && bypassReturnBits == {$past(regWdata[4:2], 2), 4'h0})
    else $error("link");
  a_rate_held: assert property (!sessionOpen |=> $stable(baseRateRange))
    else $error("base rate");
  a_pulse_single: assert property (startTimeout || endTimeout |=>
    !startTimeout && !endTimeout) else $error("pulse");
  a_start_early: assert property (sessionOpen |=> !startTimeout [*8])
    else $error("early");
endmodule
bind scr_config_regs scr_config_regs_properties i_props (.mclk, .reset_n, .regWrite,
  .regAddr, .regWdata, .sessionOpen, .startTimeout, .endTimeout, .pixelClockRange,
  .serialRateRange, .spreadSelect, .spreadOn, .powerDown, .ownLinkAddress, .fastBand,
  .bypassReturnBits, .baseRateRange);

// [tb/scr_remote_ctrl.sv]
// Remote controller model issuing register and session requests.
`timescale 1ns/1ps
module scr_remote_ctrl (
  // Clock
  input logic mclk,
  // Requests
  output logic regWrite = 1'b0,
  output logic regRead = 1'b0,
  output logic [3:0] regAddr = 4'h0,
  output logic [7:0] regWdata = 8'h00,
  output logic sessionOpen = 1'b0,
  output logic sessionClose = 1'b0,
  output logic channelUse = 1'b0,
  // Answers
  input logic [7:0] regRdata,
  input logic regRvalid
);
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [8:0] v);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 v = {regRvalid, regRdata};
  endtask
  task automatic ev(input logic [2:0] m);
    @(posedge mclk);
    {sessionOpen, sessionClose, channelUse} <= m;
    @(posedge mclk);
    {sessionOpen, sessionClose, channelUse} <= 3'b000;
  endtask
endmodule

// [tb/tb_scr_config_regs.sv]
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
module tb_scr_config_regs;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic remoteConfigInput = 1'b0;
  logic pixelTick = 1'b0;
  logic regWrite, regRead, sessionOpen, sessionClose, channelUse, regRvalid;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic startTimeout, endTimeout, spreadOn, powerDown, serializeOn, fastBand;
  logic [1:0] pixelClockRange, serialRateRange, baseRateRange;
  logic videoParityOn, jitterPllBypass, testPatternOn, peripheralIfOn;
  logic [2:0] spreadSelect, parallelWordWidth;
  logic [6:0] ownLinkAddress, bypassReturnBits, closingFrameValue, partnerLinkAddress;
  logic [8:0] v;
  logic [1:0] se;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  always #20 mclk = ~mclk;
  scr_config_regs i_scr_config_regs (.mclk, .reset_n, .remoteConfigInput, .regWrite,
    .regRead, .regAddr, .regWdata, .regRdata, .regRvalid, .sessionOpen, .sessionClose,
    .channelUse, .pixelTick, .startTimeout, .endTimeout, .pixelClockRange,
    .serialRateRange, .videoParityOn, .parallelWordWidth, .spreadSelect, .spreadOn,
    .vsyncEdgeSelect(), .pixelClockEdgeSelect(), .powerDown, .serializeOn,
    .jitterPllBypass, .testPatternOn, .ownLinkAddress, .closingFrameValue,
    .partnerLinkAddress, .peripheralIfSelect(), .peripheralIfOn, .fastBand,
    .bypassReturnBits, .baseRateRange);
  scr_remote_ctrl i_rc (.mclk, .regWrite, .regRead, .regAddr, .regWdata, .sessionOpen,
    .sessionClose, .channelUse, .regRdata, .regRvalid);
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    i_rc.rd(a, v);
    chk($sformatf("register %0d", a), {1'b1, e}, v);
  endtask
  task automatic do_reset(input logic r);
    @(posedge mclk);
    remoteConfigInput <= r;
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  // Drives n pixel ticks, then idles, collecting any timeout pulse seen.
  task automatic tick(input int n);
    se = 2'b00;
    repeat (n + 3) begin
      @(posedge mclk);
      pixelTick <= (n-- > 0);
      #1 se = se | {startTimeout, endTimeout};
    end
  endtask
  task automatic t_reset_values;
    logic [7:0] e [9] = '{8'hb5, 8'h1f, 8'ha0, 8'ha0, 8'h28, 8'hfa, 8'hff, 8'hf8, 8'h00};
    for (int i = 0; i < 9; i++) begin
      rc(i[3:0], e[i]);
    end
    do_reset(1'b1);
    rc(4'h4, 8'h30);
    chk("strap outputs", 9'h002, {7'h0, powerDown, serializeOn});
    do_reset(1'b0);
    rc(4'h4, 8'h28);
    $display("test reset values done");
  endtask
  task automatic t_masks;
    logic [19:0] t [7] = '{20'h04a4a, 20'h4ffbd, 20'h5fffe, 20'h60001, 20'h7fffe,
      20'h8ffff, 20'h95a00};
    for (int i = 0; i < 7; i++) begin
      i_rc.wr(t[i][19:16], t[i][15:8]);
      rc(t[i][19:16], t[i][7:0]);
    end
    chk("mask outputs", {1'b1, 3'h2, 1'b1, 1'b1, 1'b1, 2'b00},
      {videoParityOn, parallelWordWidth, jitterPllBypass, testPatternOn, peripheralIfOn, 2'b00});
    chk("frame value", 9'h000, {2'b00, closingFrameValue});
    chk("partner address", 9'h07f, {2'b00, partnerLinkAddress});
    $display("test masks done");
  endtask
  task automatic t_spread;
    i_rc.wr(4'h0, 8'h35);
    for (int c = 0; c < 8; c++) begin
      i_rc.wr(4'h1, {c[2:0], 5'h1f});
      @(posedge mclk);
      #1 chk("spread", {5'h0, c[2:0], c[1:0] != 2'b00}, {5'h0, spreadSelect, spreadOn});
    end
    $display("test spread done");
  endtask
  task automatic t_link;
    i_rc.wr(4'h8, 8'h00);
    i_rc.ev(3'b100);
    i_rc.wr(4'h8, 8'hfd);
    @(posedge mclk);
    #1 chk("link now", 9'h1e0, {fastBand, bypassReturnBits, 1'b0});
    chk("base held", {7'h0, baseRateRange}, 9'h000);
    i_rc.ev(3'b010);
    i_rc.ev(3'b100);
    @(posedge mclk);
    #1 chk("base next", {7'h0, baseRateRange}, 9'h001);
    i_rc.ev(3'b010);
    $display("test link done");
  endtask
  task automatic t_timeout;
    i_rc.wr(4'h2, 8'h01);
    i_rc.wr(4'h3, 8'h81);
    i_rc.ev(3'b100);
    tick(31);
    chk("start early", {7'h0, se}, 9'h000);
    tick(1);
    chk("start fire", {7'h0, se}, 9'h002);
    i_rc.ev(3'b100);
    i_rc.ev(3'b001);
    tick(511);
    chk("end early", {7'h0, se}, 9'h000);
    tick(1);
    chk("end fire", {7'h0, se}, 9'h001);
    $display("test timeout done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    do_reset(1'b0);
    t_reset_values;
    t_masks;
    t_spread;
    t_link;
    t_timeout;
    complete_run;
  end
endmodule
